// ### logic/lafc_pkg.sv
// Package of constants and types for the list based converter flow control
package lafc_pkg;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FLOW_OFS = 8'h04;
  localparam logic [7:0] ERR_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] CMD_OFS = 8'h10;
  localparam logic [7:0] RES_OFS = 8'h14;

  // Control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_ACC_LSB = 2;
  localparam int CTRL_STORE_BIT = 4;
  localparam int CTRL_AUTO_BIT = 5;
  localparam int CTRL_LOWPWR_BIT = 6;
  localparam int CTRL_RES_LSB = 7;
  localparam int CTRL_LEFT_BIT = 9;
  localparam int CTRL_SRC_BIT = 10;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // Flow request bit positions
  localparam int FL_LAUNCH = 0;
  localparam int FL_REWIND = 1;
  localparam int FL_SWAP = 2;
  localparam int FL_ABORT = 3;

  // Error flag positions
  localparam int ERR_LAUNCH_BUSY = 0;
  localparam int ERR_REWIND_BUSY = 1;
  localparam int ERR_SWAP_LATE = 2;
  localparam int ERR_DISABLED = 3;

  // Status register field positions
  localparam int ST_RIDX_LSB = 6;
  localparam int ST_CSEL_BIT = 12;
  localparam int ST_RSEL_BIT = 13;
  localparam int ST_READY_BIT = 14;
  localparam int ST_EOL_BIT = 15;
  localparam int ST_CONVIRQ_LSB = 16;

  // Access selector codes
  localparam logic [1:0] ACC_NONE = 2'h0;
  localparam logic [1:0] ACC_SIG = 2'h1;
  localparam logic [1:0] ACC_BUS = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;

  // Resolution codes
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;

  // Command word layout: [5:0] channel, [6] high ref, [7] low ref,
  // [9:8] special, [13:10] interrupt number, [15:14] end kind
  localparam int CMD_W = 16;
  localparam int CMD_DEPTH = 64;
  localparam int IDX_W = 6;
  localparam int CONV_IRQS = 15;
  localparam logic [5:0] INT_CH_BASE = 6'h38;
  localparam logic [1:0] SPC_NONE = 2'h0;
  localparam logic [1:0] SPC_HIGH = 2'h1;
  localparam logic [1:0] SPC_LOW = 2'h2;
  localparam logic [1:0] SPC_MID = 2'h3;
  localparam logic [1:0] END_NONE = 2'h0;
  localparam logic [1:0] END_LIST = 2'h1;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int REC_TIME_NS = 500;
  localparam int REC_CYCLES = (REC_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYCLES = 16;
  localparam int DISABLE_CYCLES = 4;

  typedef enum logic [2:0] {
    ST_OFF, ST_RECOVER, ST_IDLE, ST_CONVERT, ST_ABORTING, ST_DRAIN
  } lafc_state_t;

endpackage

// ### logic/lafc_core.sv
// Converter core model: fixed-length conversion with reference muxing
`timescale 1ns/100ps
module lafc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic kill,
  input wire logic [11:0] sample,
  input wire logic [11:0] ref_high,
  input wire logic [11:0] ref_low,
  input wire logic [1:0] special,
  // Result
  output logic done,
  output logic [11:0] result,
  output logic busy
);
  logic [4:0] cnt_reg;
  logic [11:0] val_reg;
  logic [12:0] mid;

  assign mid = ({1'b0, ref_high} + {1'b0, ref_low}) >> 1;
  assign busy = (cnt_reg != 5'h00);
  assign result = val_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 5'h00;
      val_reg <= 12'h000;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (kill) begin
        cnt_reg <= 5'h00;
      end else if (start && !busy) begin
        cnt_reg <= 5'(lafc_pkg::CONV_CYCLES);
        unique case (special)
          lafc_pkg::SPC_HIGH: val_reg <= ref_high;
          lafc_pkg::SPC_LOW: val_reg <= ref_low;
          lafc_pkg::SPC_MID: val_reg <= mid[11:0];
          default: val_reg <= sample;
        endcase
      end else if (busy) begin
        cnt_reg <= cnt_reg - 5'h01;
        done <= (cnt_reg == 5'h01);
      end
    end
  end
endmodule

// ### logic/lafc_top.sv
// Conversion flow control with Avalon-MM register slave
`timescale 1ns/100ps
module lafc_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Internal request inputs from on-chip trigger logic
  input wire logic launch_input,
  input wire logic rewind_input,
  input wire logic swap_permit_input,
  input wire logic abort_input,
  input wire logic stop_request,
  // Analog sample of selected channel
  input wire logic [11:0] sample_data,
  input wire logic [11:0] ref_high_0,
  input wire logic [11:0] ref_high_1,
  input wire logic [11:0] ref_low_0,
  input wire logic [11:0] ref_low_1,
  // Converter view
  output logic [5:0] channel_select,
  output logic [15:0] result_word,
  output logic result_valid
);
  logic [10:0] ctrl_reg;
  logic [3:0] flow_request_register;
  logic [3:0] flow_error_flags;
  logic [3:0] req_sync_reg;
  logic [5:0] command_index;
  logic [5:0] result_index;
  logic cmd_sel_reg;
  logic res_sel_reg;
  logic eol_flag_reg;
  logic [14:0] conv_irq_reg;
  logic [15:0] cmd_list [2][64];
  logic [15:0] res_list [2][64];
  logic [8:0] rec_cnt_reg;
  logic [2:0] dis_cnt_reg;
  logic en_prev_reg;
  logic lowpwr_prev_reg;
  lafc_pkg::lafc_state_t state_reg;
  logic [15:0] cmd;
  logic [15:0] nvm_cmd;
  logic core_done;
  logic core_busy;
  logic [11:0] core_result;
  logic conv_start;
  logic core_kill;
  logic bus_wr;
  logic bus_flow_wr;
  logic sig_ok;
  logic bus_ok;
  logic en;
  logic lowpwr;
  logic [3:0] sig_req;
  logic [3:0] bus_req;
  logic [3:0] new_req;
  logic launch_go;
  logic rewind_go;
  logic abort_done;
  logic list_end;

  assign en = ctrl_reg[lafc_pkg::CTRL_EN_BIT];
  assign lowpwr = ctrl_reg[lafc_pkg::CTRL_LOWPWR_BIT] | stop_request;

  // Fixed nonvolatile command table
  function automatic logic [15:0] nvm_entry(input logic [5:0] idx);
    nvm_entry = {lafc_pkg::END_NONE, 4'(idx[3:0]), lafc_pkg::SPC_NONE, 2'h0, idx};
    if (idx == 6'h03) begin
      nvm_entry[15:14] = lafc_pkg::END_LIST;
    end
  endfunction

  // Resolution and alignment of a raw result
  function automatic logic [15:0] shape(input logic [11:0] raw, input logic [1:0] res,
                                        input logic left);
    logic [11:0] r;
    r = raw;
    unique case (res)
      lafc_pkg::RES_8: r = {4'h0, raw[11:4]};
      lafc_pkg::RES_10: r = {2'h0, raw[11:2]};
      default: r = raw;
    endcase
    if (left) begin
      unique case (res)
        lafc_pkg::RES_8: shape = {r[7:0], 8'h00};
        lafc_pkg::RES_10: shape = {r[9:0], 6'h00};
        default: shape = {r, 4'h0};
      endcase
    end else begin
      shape = {4'h0, r};
    end
  endfunction

  assign nvm_cmd = nvm_entry(command_index);
  // Command source: RAM copy or fixed table
  assign cmd = ctrl_reg[lafc_pkg::CTRL_SRC_BIT] ? nvm_cmd
             : cmd_list[cmd_sel_reg][command_index];

  // ==========================================================
  // Bus slave
  assign bus_wr = avs_write && !avs_waitrequest;
  assign bus_flow_wr = bus_wr && avs_address == lafc_pkg::FLOW_OFS && avs_byteenable[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en && avs_read && avs_waitrequest) begin
      unique case (avs_address)
        lafc_pkg::CTRL_OFS: avs_readdata <= {21'h000000, ctrl_reg};
        lafc_pkg::FLOW_OFS: avs_readdata <= {28'h0000000, flow_request_register};
        lafc_pkg::ERR_OFS: avs_readdata <= {28'h0000000, flow_error_flags};
        lafc_pkg::STAT_OFS: avs_readdata <= {1'b0, conv_irq_reg, eol_flag_reg,
            state_reg == lafc_pkg::ST_IDLE, res_sel_reg, cmd_sel_reg,
            result_index, command_index};
        lafc_pkg::CMD_OFS: avs_readdata <= {16'h0000, cmd};
        lafc_pkg::RES_OFS: avs_readdata <= {16'h0000, res_list[res_sel_reg][result_index]};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Control register; enable may only rise once disable drain is over
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= lafc_pkg::CTRL_RESET;
    end else if (clk_en && bus_wr && avs_address == lafc_pkg::CTRL_OFS) begin
      ctrl_reg <= avs_writedata[10:0];
      if (dis_cnt_reg != 3'h0 && !en) begin
        ctrl_reg[lafc_pkg::CTRL_EN_BIT] <= 1'b0;
      end
    end
  end

  // Command list writes: write data bits above the command word pick entry and copy
  always_ff @(posedge clk) begin
    if (clk_en && bus_wr && avs_address == lafc_pkg::CMD_OFS) begin
      cmd_list[avs_writedata[22]][avs_writedata[21:16]] <= avs_writedata[15:0];
    end
  end

  // ==========================================================
  // Request capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_sync_reg <= 4'h0;
    end else if (clk_en) begin
      req_sync_reg <= {abort_input, swap_permit_input, rewind_input, launch_input};
    end
  end

  assign sig_ok = ctrl_reg[3:2] == lafc_pkg::ACC_SIG || ctrl_reg[3:2] == lafc_pkg::ACC_BOTH;
  assign bus_ok = ctrl_reg[3:2] == lafc_pkg::ACC_BUS || ctrl_reg[3:2] == lafc_pkg::ACC_BOTH;
  assign sig_req = sig_ok ? req_sync_reg : 4'h0;
  assign bus_req = (bus_ok && bus_flow_wr) ? avs_writedata[3:0] : 4'h0;
  assign new_req = (en && !lowpwr) ? (sig_req | bus_req) : 4'h0;

  // ==========================================================
  // Sequencer
  assign list_end = cmd[15:14] == lafc_pkg::END_LIST || command_index == 6'h3f;
  assign launch_go = flow_request_register[lafc_pkg::FL_LAUNCH] &&
                     state_reg == lafc_pkg::ST_IDLE &&
                     (!ctrl_reg[lafc_pkg::CTRL_MODE_BIT] ||
                      !flow_request_register[lafc_pkg::FL_REWIND]);
  assign rewind_go = flow_request_register[lafc_pkg::FL_REWIND] &&
                     state_reg == lafc_pkg::ST_IDLE;
  assign abort_done = state_reg == lafc_pkg::ST_ABORTING && !core_busy;
  assign conv_start = launch_go;
  assign core_kill = (en_prev_reg && !en) ||
                     (state_reg == lafc_pkg::ST_ABORTING && !en);

  // Flow request bits: set by request, held during event, cleared at its end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_request_register <= 4'h0;
    end else if (clk_en) begin
      if (lowpwr || !en) begin
        flow_request_register <= 4'h0;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (new_req[i]) begin
            flow_request_register[i] <= 1'b1;
          end
        end
        if (core_done && state_reg == lafc_pkg::ST_CONVERT && !new_req[lafc_pkg::FL_LAUNCH]) begin
          flow_request_register[lafc_pkg::FL_LAUNCH] <= 1'b0;
        end
        if (rewind_go && !new_req[lafc_pkg::FL_REWIND]) begin
          flow_request_register[lafc_pkg::FL_REWIND] <= 1'b0;
        end
        if (abort_done && !new_req[lafc_pkg::FL_ABORT]) begin
          flow_request_register[lafc_pkg::FL_ABORT] <= 1'b0;
        end
        if (list_end && core_done && !new_req[lafc_pkg::FL_SWAP]) begin
          flow_request_register[lafc_pkg::FL_SWAP] <= 1'b0;
        end
      end
    end
  end

  // Error flags: write one to clear, set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_error_flags <= 4'h0;
    end else if (clk_en) begin
      logic [3:0] set;
      set = 4'h0;
      set[lafc_pkg::ERR_LAUNCH_BUSY] = new_req[lafc_pkg::FL_LAUNCH] &&
                                       flow_request_register[lafc_pkg::FL_LAUNCH];
      set[lafc_pkg::ERR_REWIND_BUSY] = new_req[lafc_pkg::FL_REWIND] &&
                                       state_reg == lafc_pkg::ST_CONVERT &&
                                       ctrl_reg[lafc_pkg::CTRL_MODE_BIT];
      set[lafc_pkg::ERR_SWAP_LATE] = list_end && core_done &&
                                     !flow_request_register[lafc_pkg::FL_SWAP];
      set[lafc_pkg::ERR_DISABLED] = !en && ((sig_req | bus_req) != 4'h0);
      if (bus_wr && avs_address == lafc_pkg::ERR_OFS) begin
        flow_error_flags <= (flow_error_flags & ~avs_writedata[3:0]) | set;
      end else begin
        flow_error_flags <= flow_error_flags | set;
      end
    end
  end

  // Enable edge, recovery and disable drain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_prev_reg <= 1'b0;
      lowpwr_prev_reg <= 1'b0;
      rec_cnt_reg <= 9'h000;
      dis_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      en_prev_reg <= en;
      lowpwr_prev_reg <= lowpwr;
      if (en && !en_prev_reg) begin
        rec_cnt_reg <= 9'(lafc_pkg::REC_CYCLES);
      end else if (rec_cnt_reg != 9'h000) begin
        rec_cnt_reg <= rec_cnt_reg - 9'h001;
      end
      if (en_prev_reg && !en) begin
        dis_cnt_reg <= 3'(lafc_pkg::DISABLE_CYCLES);
      end else if (dis_cnt_reg != 3'h0) begin
        dis_cnt_reg <= dis_cnt_reg - 3'h1;
      end
    end
  end

  // State machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= lafc_pkg::ST_OFF;
    end else if (clk_en) begin
      if (!en) begin
        state_reg <= (dis_cnt_reg != 3'h0) ? lafc_pkg::ST_DRAIN : lafc_pkg::ST_OFF;
      end else begin
        unique case (state_reg)
          lafc_pkg::ST_OFF, lafc_pkg::ST_DRAIN: state_reg <= lafc_pkg::ST_RECOVER;
          lafc_pkg::ST_RECOVER:
            if (rec_cnt_reg == 9'h001 || rec_cnt_reg == 9'h000) begin
              state_reg <= lafc_pkg::ST_IDLE;
            end
          lafc_pkg::ST_IDLE:
            if (flow_request_register[lafc_pkg::FL_ABORT] || lowpwr) begin
              state_reg <= lafc_pkg::ST_ABORTING;
            end else if (launch_go) begin
              state_reg <= lafc_pkg::ST_CONVERT;
            end
          lafc_pkg::ST_CONVERT:
            if (flow_request_register[lafc_pkg::FL_ABORT] || lowpwr) begin
              state_reg <= lafc_pkg::ST_ABORTING;
            end else if (core_done) begin
              state_reg <= lafc_pkg::ST_IDLE;
            end
          lafc_pkg::ST_ABORTING:
            if (abort_done) begin
              state_reg <= lafc_pkg::ST_IDLE;
            end
        endcase
      end
    end
  end

  // Indices, buffers, result list and interrupt flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_index <= 6'h00;
      result_index <= 6'h00;
      cmd_sel_reg <= 1'b0;
      res_sel_reg <= 1'b0;
      eol_flag_reg <= 1'b0;
      conv_irq_reg <= 15'h0000;
      result_valid <= 1'b0;
      result_word <= 16'h0000;
      channel_select <= 6'h00;
    end else if (clk_en) begin
      logic store;
      store = core_done && en &&
              (state_reg == lafc_pkg::ST_CONVERT ||
               ctrl_reg[lafc_pkg::CTRL_STORE_BIT]);
      result_valid <= store;
      channel_select <= cmd[5:0];
      if (bus_wr && avs_address == lafc_pkg::STAT_OFS) begin
        eol_flag_reg <= eol_flag_reg & ~avs_writedata[lafc_pkg::ST_EOL_BIT];
        conv_irq_reg <= conv_irq_reg & ~avs_writedata[30:16];
      end
      if (store) begin
        result_word <= shape(core_result, ctrl_reg[8:7], ctrl_reg[lafc_pkg::CTRL_LEFT_BIT]);
        res_list[res_sel_reg][result_index] <= shape(core_result, ctrl_reg[8:7],
                                                     ctrl_reg[lafc_pkg::CTRL_LEFT_BIT]);
        result_index <= result_index + 6'h01;
        command_index <= command_index + 6'h01;
        if (cmd[13:10] != 4'hf) begin
          conv_irq_reg[cmd[13:10]] <= 1'b1;
        end
        if (list_end) begin
          eol_flag_reg <= 1'b1;
          command_index <= 6'h00;
          result_index <= 6'h00;
          if (flow_request_register[lafc_pkg::FL_SWAP]) begin
            cmd_sel_reg <= !cmd_sel_reg;
            res_sel_reg <= !res_sel_reg;
          end
        end
      end
      if (rewind_go || (!lowpwr && lowpwr_prev_reg && ctrl_reg[lafc_pkg::CTRL_AUTO_BIT])) begin
        command_index <= 6'h00;
        result_index <= 6'h00;
      end
      if (!en) begin
        command_index <= 6'h00;
        result_index <= 6'h00;
      end
    end
  end

  lafc_core u_core (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(conv_start),
    .kill(core_kill),
    .sample(sample_data),
    .ref_high(cmd[6] ? ref_high_1 : ref_high_0),
    .ref_low(cmd[7] ? ref_low_1 : ref_low_0),
    .special(cmd[9:8]),
    .done(core_done),
    .result(core_result),
    .busy(core_busy)
  );
endmodule

// ### dv/lafc_sva.sv
// Port checker for the conversion flow control block
`timescale 1ns/100ps
module lafc_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Flow side
  input wire logic stop_request,
  input wire logic result_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Bus handshake
  property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low twice");
  property p_wait_cause; !avs_waitrequest |-> avs_read || avs_write; endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("accept without request");
  property p_wait_ans; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_rd_stand; $changed(avs_readdata) |-> !avs_waitrequest; endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 8'h20 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========
  // Flow and results
  property p_lowpwr;
    avs_read && !avs_waitrequest && avs_address == lafc_pkg::FLOW_OFS && stop_request
      && $past(stop_request, 2) |-> avs_readdata[3:0] == 4'h0;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("flow bits set in low power");
  property p_valid_pulse; result_valid |=> !result_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result pulse too long");
  property p_reset_idle; $rose(reset_n) |-> avs_waitrequest && !result_valid; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  c_result: cover property (result_valid);
  c_lowpwr: cover property (stop_request && avs_read && !avs_waitrequest);
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address == 8'h20);
endmodule
bind lafc_top lafc_sva i_sva (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .stop_request(stop_request),
  .result_valid(result_valid));

// ### dv/lafc_launch_request_model.sv
// On-chip trigger logic model driving the flow request inputs
`timescale 1ns/100ps
module lafc_launch_request_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench commands, one bit per request
  input wire logic [3:0] fire,
  // Request wires
  output logic launch_input,
  output logic rewind_input,
  output logic swap_permit_input,
  output logic abort_input,
  // Analog side
  output logic [11:0] sample_data,
  output logic [11:0] ref_high_0,
  output logic [11:0] ref_high_1,
  output logic [11:0] ref_low_0,
  output logic [11:0] ref_low_1
);
  // ==========
  // One-cycle pulses, one wire per flow bit, each driven from its own fire bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {abort_input, swap_permit_input, rewind_input, launch_input} <= 4'h0;
    end else begin
      {abort_input, swap_permit_input, rewind_input, launch_input} <= fire;
    end
  end
  // Sample moves every cycle so a stale capture shows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_data <= 12'h0;
    end else begin
      sample_data <= sample_data + 12'h035;
    end
  end
  assign ref_high_0 = 12'hf00;
  assign ref_high_1 = 12'he10;
  assign ref_low_0 = 12'h010;
  assign ref_low_1 = 12'h020;
endmodule

// ### dv/tb.sv
// Self-checking bench for the conversion flow control block
`timescale 1ns/100ps
module tb;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, stop_request, result_valid;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic launch_input, rewind_input, swap_permit_input, abort_input;
  logic [11:0] sample_data, ref_high_0, ref_high_1, ref_low_0, ref_low_1;
  logic [5:0] channel_select, last_ch;
  logic [15:0] result_word, last_res;
  logic [3:0] fire;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_valid = 0;
  int got;
  lafc_top i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .launch_input(launch_input), .rewind_input(rewind_input),
    .swap_permit_input(swap_permit_input), .abort_input(abort_input),
    .stop_request(stop_request), .sample_data(sample_data), .ref_high_0(ref_high_0),
    .ref_high_1(ref_high_1), .ref_low_0(ref_low_0), .ref_low_1(ref_low_1),
    .channel_select(channel_select), .result_word(result_word), .result_valid(result_valid));
  lafc_launch_request_model i_launch_request (.clk(clk), .reset_n(reset_n), .fire(fire),
    .launch_input(launch_input), .rewind_input(rewind_input),
    .swap_permit_input(swap_permit_input), .abort_input(abort_input),
    .sample_data(sample_data), .ref_high_0(ref_high_0), .ref_high_1(ref_high_1),
    .ref_low_0(ref_low_0), .ref_low_1(ref_low_1));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Result monitor and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (result_valid === 1'b1) begin
      n_valid <= n_valid + 1;
      last_ch <= channel_select;
      last_res <= result_word;
    end
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycle held until waitrequest is sampled low, then one idle cycle
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ctrl_w(input logic en, input logic [1:0] acc);
    ctrl_w = 32'h0;
    ctrl_w[lafc_pkg::CTRL_EN_BIT] = en;
    ctrl_w[lafc_pkg::CTRL_ACC_LSB +: 2] = acc;
  endfunction
  task automatic pulse(input logic [3:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic watch(input int n);
    int v0;
    v0 = n_valid;
    repeat (n) @(posedge clk);
    got = n_valid - v0;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    bus(1'b0, lafc_pkg::CTRL_OFS, 32'h0);
    chk(rd_val, {21'h0, lafc_pkg::CTRL_RESET});
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd_val, 32'h0);
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b0, lafc_pkg::ACC_BUS));
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h1);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h0);
    bus(1'b0, lafc_pkg::ERR_OFS, 32'h0);
    chk(rd_val, 32'h1 << lafc_pkg::ERR_DISABLED);
  endtask
  task automatic t_access();
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b1, lafc_pkg::ACC_BUS));
    pulse(4'h4);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h0);
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h4);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h4);
    stop_request <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h0);
    stop_request <= 1'b0;
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b1, lafc_pkg::ACC_SIG));
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h4);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h0);
    pulse(4'h4);
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk(rd_val, 32'h4);
  endtask
  task automatic t_convert();
    bus(1'b1, lafc_pkg::CMD_OFS, {16'h0, lafc_pkg::END_LIST, 4'h0, lafc_pkg::SPC_HIGH, 8'h05});
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b1, lafc_pkg::ACC_BOTH));
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h1);
    watch(3 * lafc_pkg::CONV_CYCLES);
    chk(32'(got), 32'h1);
    chk({26'h0, last_ch}, 32'h5);
    chk({16'h0, last_res}, {24'h0, ref_high_0[11:4]});
    bus(1'b0, lafc_pkg::FLOW_OFS, 32'h0);
    chk({31'h0, rd_val[lafc_pkg::FL_LAUNCH]}, 32'h0);
  endtask
  task automatic t_disable();
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h1);
    repeat (4) @(posedge clk);
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b0, lafc_pkg::ACC_BOTH));
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b1, lafc_pkg::ACC_BOTH));
    bus(1'b0, lafc_pkg::CTRL_OFS, 32'h0);
    chk(rd_val, ctrl_w(1'b0, lafc_pkg::ACC_BOTH));
    watch(lafc_pkg::CONV_CYCLES + 8);
    chk(32'(got), 32'h0);
    repeat (lafc_pkg::DISABLE_CYCLES) @(posedge clk);
    bus(1'b1, lafc_pkg::CTRL_OFS, ctrl_w(1'b1, lafc_pkg::ACC_BOTH));
    bus(1'b1, lafc_pkg::FLOW_OFS, 32'h1);
    watch(lafc_pkg::REC_CYCLES - 8);
    chk(32'(got), 32'h0);
  endtask
  initial begin
    reset_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    stop_request = 1'b0;
    fire = 4'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_access();
    t_convert();
    t_disable();
    summarize();
  end
endmodule
